// >>> core/pum_params.svh
// Purpose: Constants for the packet user port and maintenance access block
// Assumes: Included by the package and the design modules
// Notes:   Field positions of the header-encoded word and maintenance codes
`ifndef PUM_PARAMS_SVH
`define PUM_PARAMS_SVH
`define PUM_HDR_TAG_HI     63
`define PUM_HDR_TAG_LO     56
`define PUM_HDR_CLASS_HI   55
`define PUM_HDR_CLASS_LO   52
`define PUM_HDR_TYPE_HI    51
`define PUM_HDR_TYPE_LO    48
`define PUM_HDR_PRIO_HI    46
`define PUM_HDR_PRIO_LO    45
`define PUM_HDR_CRIT_BIT   44
`define PUM_HDR_SIZE_HI    43
`define PUM_HDR_SIZE_LO    36
`define PUM_HDR_ERR_BIT    35
`define PUM_HDR_ADDR_HI    33
`define PUM_HDR_ADDR_LO    0
`define PUM_ALIGN_MASK     3'h7
`define PUM_SIZE_DWORD     8'h07
`define PUM_SIZE_MAX       8'hFF
`define PUM_SIZE_2DW       8'h0F
`define PUM_SIZE_4DW       8'h1F
`define PUM_SIZE_8DW       8'h3F
`define PUM_SIZE_16DW      8'h7F
`define PUM_SIZE_12DW      8'h5F
`define PUM_SIZE_20DW      8'h9F
`define PUM_SIZE_24DW      8'hBF
`define PUM_SIZE_28DW      8'hDF
`define PUM_CLASS_READ     4'h2
`define PUM_MNT_OFS_HI     23
`define PUM_MNT_HOP_HI     31
`define PUM_MNT_HOP_LO     24
`define PUM_STRB_WORD      4'hF
`define PUM_RESP_OKAY      2'h0
`define PUM_RESP_SLVERR    2'h2
`define PUM_STAT_DONE      4'h0
`endif

// >>> core/pum_pkg.sv
// Purpose: Types shared by the packet user port and maintenance access block
// Assumes: pum_params.svh provides the numeric constants
// Notes:   Stream beats and maintenance requests travel as packed structs
`include "pum_params.svh"
package pum_pkg;
  typedef struct packed {
    logic [63:0] data;
    logic [7:0]  keep;
    logic [31:0] user;
    logic        last;
  } pum_beat_t;

  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [31:0] data;
  } pum_mreq_t;

  typedef struct packed {
    logic        err;
    logic [31:0] data;
  } pum_mrsp_t;

  typedef enum logic {PUM_FMT_HDR_ENC, PUM_FMT_STREAM} pum_fmt_t;
endpackage : pum_pkg

// >>> core/pum_maint_port.sv
// Purpose: Lite-bus maintenance port, one outstanding read and one write
// Assumes: Same clock as the logical layer; completions come from config fabric
// Notes:   Write forwarded only after both address and data are held
`timescale 1ns/1ps
`include "pum_params.svh"
module pum_maint_port (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_awvalid,
  output logic                  o_awready,
  input  wire logic [31:0]      i_awaddr,
  input  wire logic             i_wvalid,
  output logic                  o_wready,
  input  wire logic [31:0]      i_wdata,
  input  wire logic [3:0]       i_wstrb,
  output logic                  o_bvalid,
  input  wire logic             i_bready,
  output logic [1:0]            o_bresp,
  input  wire logic             i_arvalid,
  output logic                  o_arready,
  input  wire logic [31:0]      i_araddr,
  output logic                  o_rvalid,
  input  wire logic             i_rready,
  output logic [31:0]           o_rdata,
  output logic [1:0]            o_rresp,
  output logic                  o_req_valid,
  input  wire logic             i_req_ready,
  output pum_pkg::pum_mreq_t    o_req,
  input  wire logic             i_cpl_valid,
  input  wire logic             i_cpl_write,
  input  wire pum_pkg::pum_mrsp_t i_cpl
);
  import pum_pkg::*;

  logic aw_have_r, w_have_r, wr_busy_r, wr_sent_r, bvalid_r;
  logic rd_busy_r, rd_sent_r, rvalid_r;
  logic [31:0] awaddr_r, wdata_r, araddr_r, rdata_r;
  logic [1:0]  bresp_r, rresp_r;
  logic wbad_r;

  // Channel handshakes; new write held off until its response is handed over
  wire aw_fire  = i_awvalid & o_awready;
  wire w_fire   = i_wvalid & o_wready;
  wire ar_fire  = i_arvalid & o_arready;
  wire wr_ready = aw_have_r & w_have_r & ~wr_sent_r;
  wire rd_ready = rd_busy_r & ~rd_sent_r & ~wr_ready;
  wire req_fire = o_req_valid & i_req_ready;
  wire wcpl     = i_cpl_valid & i_cpl_write & wr_sent_r & ~bvalid_r;
  wire rcpl     = i_cpl_valid & ~i_cpl_write & rd_sent_r & ~rvalid_r;
  assign o_awready = ~aw_have_r & ~wr_busy_r;
  assign o_wready  = ~w_have_r & ~wr_busy_r;
  assign o_arready = ~rd_busy_r;
  assign o_req_valid = wr_ready | rd_ready;
  assign o_req = wr_ready ? pum_mreq_t'{write: 1'b1, addr: awaddr_r, data: wdata_r}
                          : pum_mreq_t'{write: 1'b0, addr: araddr_r, data: 32'h0000_0000};
  assign o_bvalid = bvalid_r;
  assign o_bresp  = bresp_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata  = rdata_r;
  assign o_rresp  = rresp_r;

  // Write channel state; partial strobes are not a single word, answered error
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      wr_busy_r <= 1'b0;
      wr_sent_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `PUM_RESP_OKAY;
      awaddr_r  <= 32'h0000_0000;
      wdata_r   <= 32'h0000_0000;
      wbad_r    <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= i_awaddr;
      end
      if (w_fire) begin
        w_have_r <= 1'b1;
        wdata_r  <= i_wdata;
        wbad_r   <= (i_wstrb != `PUM_STRB_WORD);
      end
      if (aw_fire | w_fire) wr_busy_r <= (aw_have_r | aw_fire) & (w_have_r | w_fire);
      if (req_fire & wr_ready) wr_sent_r <= 1'b1;
      if (wcpl) begin
        bvalid_r <= 1'b1;
        bresp_r  <= (i_cpl.err | wbad_r) ? `PUM_RESP_SLVERR : `PUM_RESP_OKAY;
      end
      if (bvalid_r & i_bready) begin
        bvalid_r  <= 1'b0;
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        wr_busy_r <= 1'b0;
        wr_sent_r <= 1'b0;
      end
    end
  end

  // Read channel state, forwarded once the address is taken and no write is ready to go
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_busy_r <= 1'b0;
      rd_sent_r <= 1'b0;
      rvalid_r  <= 1'b0;
      araddr_r  <= 32'h0000_0000;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `PUM_RESP_OKAY;
    end else begin
      if (ar_fire) begin
        rd_busy_r <= 1'b1;
        araddr_r  <= i_araddr;
      end
      if (req_fire & ~wr_ready) rd_sent_r <= 1'b1;
      if (rcpl) begin
        rvalid_r <= 1'b1;
        rdata_r  <= i_cpl.data;
        rresp_r  <= i_cpl.err ? `PUM_RESP_SLVERR : `PUM_RESP_OKAY;
      end
      if (rvalid_r & i_rready) begin
        rvalid_r  <= 1'b0;
        rd_busy_r <= 1'b0;
        rd_sent_r <= 1'b0;
      end
    end
  end
endmodule : pum_maint_port

// >>> core/pum_user_port.sv
// Purpose: Logical-layer user port: request framing, response header, maintenance
// Assumes: One clock shared with the logical layer; far side is user logic
// Notes:   Beats pass straight through; only header checks, response error bit and sideband capture
// Behaviour
// - Sizes of a doubleword or more limited to permitted set; some reads only.
// - Short writes end at last marker; only supplied beats are transmitted.
// - Encoded format: first beat is header, payload follows one doubleword per beat.
// - Source and destination IDs captured from sideband on first beat only.
// - Packet ends on last beat; header-only is one beat; back-to-back allowed.
// - Either side stalls; beat moves only when valid and ready both high.
// - Full packet format carries all fields plus priority, passed unchanged.
// - Configuration accesses are exactly one 32-bit word.
// - Reserved configuration offsets complete normally without error; here the fabric's completion status is passed back unchanged.
// - Writes to read-only capability registers complete normally, unchanged; here the fabric's completion status is passed back unchanged.
// - Maintenance write forwarded only after address and data both taken.
// - Maintenance write status returned on write response after completion.
// - New write address or data held off until current response handed over.
// - Maintenance read forwarded once its address is taken; answer on read channel.
// - New read address refused until current read response transferred.
// - Header fields: tag, class, type, priority, flag, size, error, address.
// - Received response header error bit clear for DONE, set otherwise.
`timescale 1ns/1ps
`include "pum_params.svh"
module pum_user_port (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire pum_pkg::pum_fmt_t i_fmt,
  // Request stream from user logic
  input  wire logic              i_ureq_tvalid,
  output logic                   o_ureq_tready,
  input  wire pum_pkg::pum_beat_t i_ureq,
  // Request stream toward the logical layer
  output logic                   o_lreq_tvalid,
  input  wire logic              i_lreq_tready,
  output pum_pkg::pum_beat_t     o_lreq,
  output logic [31:0]            o_lreq_ids,
  output logic                   o_size_bad,
  // Response stream from the logical layer, status beside the header
  input  wire logic              i_lrsp_tvalid,
  output logic                   o_lrsp_tready,
  input  wire pum_pkg::pum_beat_t i_lrsp,
  input  wire logic [3:0]        i_lrsp_status,
  // Response stream to user logic
  output logic                   o_ursp_tvalid,
  input  wire logic              i_ursp_tready,
  output pum_pkg::pum_beat_t     o_ursp,
  output logic [31:0]            o_ursp_ids,
  // Maintenance lite-bus port
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_awaddr,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  output logic [1:0]             o_bresp,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  input  wire logic [31:0]       i_araddr,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  // Configuration fabric side
  output logic                   o_mreq_valid,
  input  wire logic              i_mreq_ready,
  output pum_pkg::pum_mreq_t     o_mreq,
  input  wire logic              i_mcpl_valid,
  input  wire logic              i_mcpl_write,
  input  wire pum_pkg::pum_mrsp_t i_mcpl
);
  import pum_pkg::*;

  logic        req_first_r, rsp_first_r, size_bad_r;
  logic [31:0] req_ids_r, rsp_ids_r;

  // Size check on a request header: permitted codes of a doubleword or more
  function automatic logic size_ok(input logic [7:0] sz, input logic is_read);
    logic both;
    logic rd;
    both = (sz == `PUM_SIZE_DWORD) ||
           (sz == `PUM_SIZE_2DW)   ||
           (sz == `PUM_SIZE_4DW)   ||
           (sz == `PUM_SIZE_8DW)   ||
           (sz == `PUM_SIZE_16DW)  ||
           (sz == `PUM_SIZE_MAX);
    rd   = (sz == `PUM_SIZE_12DW)  ||                                // Reads only
           (sz == `PUM_SIZE_20DW)  ||
           (sz == `PUM_SIZE_24DW)  ||
           (sz == `PUM_SIZE_28DW);
    size_ok = (sz < `PUM_SIZE_DWORD) || both || (is_read && rd);
  endfunction : size_ok

  // Request header decode on the first beat
  wire       req_fire  = i_ureq_tvalid & o_ureq_tready;
  wire [7:0] req_size  = i_ureq.data[`PUM_HDR_SIZE_HI:`PUM_HDR_SIZE_LO];
  wire [3:0] req_class = i_ureq.data[`PUM_HDR_CLASS_HI:`PUM_HDR_CLASS_LO];
  wire       req_read  = (req_class == `PUM_CLASS_READ);
  wire       req_check = req_fire & req_first_r & (i_fmt == PUM_FMT_HDR_ENC);
  wire       req_bad   = req_check & ~size_ok(req_size, req_read);

  // Pass-through; beats move only on valid and ready, ends follow last flag
  assign o_lreq_tvalid = i_ureq_tvalid;
  assign o_ureq_tready = i_lreq_tready;
  assign o_lreq        = i_ureq;
  assign o_lreq_ids    = req_first_r ? i_ureq.user : req_ids_r;
  assign o_size_bad    = size_bad_r;

  // Track first beat of each request packet and hold its IDs
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_first_r <= 1'b1;
      req_ids_r   <= 32'h0000_0000;
      size_bad_r  <= 1'b0;
    end else begin
      if (req_fire) req_first_r <= i_ureq.last;
      if (req_fire & req_first_r) req_ids_r <= i_ureq.user;
      if (req_check) size_bad_r <= req_bad;
    end
  end

  // Response header: error bit from status, only on encoded-format header beat
  wire rsp_fire = i_lrsp_tvalid & o_lrsp_tready;
  wire rsp_hdr  = rsp_first_r & (i_fmt == PUM_FMT_HDR_ENC);
  wire rsp_err  = (i_lrsp_status != `PUM_STAT_DONE);
  pum_beat_t rsp_beat;
  always_comb begin
    rsp_beat = i_lrsp;
    if (rsp_hdr) rsp_beat.data[`PUM_HDR_ERR_BIT] = rsp_err;
  end
  assign o_ursp_tvalid = i_lrsp_tvalid;
  assign o_lrsp_tready = i_ursp_tready;
  assign o_ursp        = rsp_beat;
  assign o_ursp_ids    = rsp_first_r ? i_lrsp.user : rsp_ids_r;

  // Track first beat of each response packet
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rsp_first_r <= 1'b1;
      rsp_ids_r   <= 32'h0000_0000;
    end else begin
      if (rsp_fire) rsp_first_r <= i_lrsp.last;
      if (rsp_fire & rsp_first_r) rsp_ids_r <= i_lrsp.user;
    end
  end

  // Maintenance port; reserved and read-only targets answer per fabric status
  pum_maint_port u_maint (
    .i_sys_clk  (i_sys_clk),
    .i_rst_n    (i_rst_n),
    .i_awvalid  (i_awvalid),
    .o_awready  (o_awready),
    .i_awaddr   (i_awaddr),
    .i_wvalid   (i_wvalid),
    .o_wready   (o_wready),
    .i_wdata    (i_wdata),
    .i_wstrb    (i_wstrb),
    .o_bvalid   (o_bvalid),
    .i_bready   (i_bready),
    .o_bresp    (o_bresp),
    .i_arvalid  (i_arvalid),
    .o_arready  (o_arready),
    .i_araddr   (i_araddr),
    .o_rvalid   (o_rvalid),
    .i_rready   (i_rready),
    .o_rdata    (o_rdata),
    .o_rresp    (o_rresp),
    .o_req_valid(o_mreq_valid),
    .i_req_ready(i_mreq_ready),
    .o_req      (o_mreq),
    .i_cpl_valid(i_mcpl_valid),
    .i_cpl_write(i_mcpl_write),
    .i_cpl      (i_mcpl)
  );
endmodule : pum_user_port

// >>> bench/pum_user_port_asserts.sv
// Purpose: Port checks for the packet user port
// Assumes: Bound to pum_user_port, one clock domain
// Notes:   First-beat trackers follow both streams
`timescale 1ns/1ps
module pum_user_port_asserts
  import pum_pkg::*;
(
  input wire logic i_sys_clk, i_rst_n, i_ureq_tvalid, i_lreq_tready, i_lrsp_tvalid,
  input wire logic i_ursp_tready, o_ursp_tvalid, i_awvalid, o_awready, i_wvalid,
  input wire logic o_wready, o_bvalid, i_bready, o_arready, o_rvalid,
  input wire logic o_mreq_valid, i_mcpl_valid, i_mcpl_write,
  input wire pum_pkg::pum_fmt_t  i_fmt,
  input wire pum_pkg::pum_beat_t i_ureq, i_lrsp, o_ursp,
  input wire logic [31:0]        o_lreq_ids, i_awaddr, i_wdata, o_rdata,
  input wire logic [3:0]         i_lrsp_status,
  input wire logic [1:0]         o_bresp, o_rresp,
  input wire pum_pkg::pum_mreq_t o_mreq,
  input wire pum_pkg::pum_mrsp_t i_mcpl
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic rq_first_r;
  logic rs_first_r;
  // Mark the header beat of each packet on both streams
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rq_first_r <= 1'b1;
      rs_first_r <= 1'b1;
    end else begin
      if (i_ureq_tvalid && i_lreq_tready) rq_first_r <= i_ureq.last;
      if (i_lrsp_tvalid && i_ursp_tready) rs_first_r <= i_lrsp.last;
    end
  end
  ids_first_a: assert property (rq_first_r && i_ureq_tvalid |-> o_lreq_ids == i_ureq.user)
    else $error("ids not taken on first beat");
  ids_hold_a: assert property (!rq_first_r && i_ureq_tvalid |-> $stable(o_lreq_ids))
    else $error("ids moved after first beat");
  err_bit_a: assert property (rs_first_r && o_ursp_tvalid && i_fmt == PUM_FMT_HDR_ENC
    |-> o_ursp.data[35] == (i_lrsp_status != 4'h0)) else $error("bad response error bit");
  wr_fwd_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready
    |=> o_mreq_valid && o_mreq.write && o_mreq.addr == $past(i_awaddr)
        && o_mreq.data == $past(i_wdata))
    else $error("write not forwarded");
  wr_hold_a: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while response pending");
  b_stand_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  b_code_a: assert property (i_mcpl_valid && i_mcpl_write
    |=> o_bvalid && (!$past(i_mcpl.err) || o_bresp == 2'h2)) else $error("bad write status");
  rd_hold_a: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while response pending");
  rd_ret_a: assert property (i_mcpl_valid && !i_mcpl_write |=> o_rvalid
    ##0 (o_rdata == $past(i_mcpl.data) && o_rresp == ($past(i_mcpl.err) ? 2'h2 : 2'h0)))
    else $error("bad read response");
endmodule : pum_user_port_asserts

// >>> bench/pum_fabric_model.sv
// Purpose: Configuration fabric answering maintenance accesses
// Assumes: One access at a time, random answer delay
// Notes:   Only the fault offset answers with an error
`timescale 1ns/1ps
module pum_fabric_model
  import pum_pkg::*;
#(parameter logic [23:0] FAULT_OFS = 24'h00FFFC)
(
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_req_valid,
  output logic                    o_req_ready,
  input  wire pum_pkg::pum_mreq_t i_req,
  output logic                    o_cpl_valid,
  output logic                    o_cpl_write,
  output pum_pkg::pum_mrsp_t      o_cpl
);
  int        wait_cnt;
  pum_mreq_t held;
  // Take one access, answer after one to six cycles
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_cnt <= 0;
      o_req_ready <= 1'b1;
      o_cpl_valid <= 1'b0;
      o_cpl_write <= 1'b0;
      o_cpl <= '0;
    end else begin
      o_cpl_valid <= 1'b0;
      o_cpl.data <= ~o_cpl.data;                 // Idle data never holds
      if (o_req_ready && i_req_valid) begin
        held <= i_req;
        o_req_ready <= 1'b0;
        wait_cnt <= $urandom_range(6, 1);
      end else if (wait_cnt == 1) begin
        o_cpl_valid <= 1'b1;
        o_cpl_write <= held.write;
        o_cpl.err <= held.addr[23:0] == FAULT_OFS;
        o_cpl.data <= ~held.addr;
        o_req_ready <= 1'b1;
        wait_cnt <= 0;
      end else if (wait_cnt > 1) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule : pum_fabric_model

// >>> bench/tb_top.sv
// Purpose: Self-checking bench for the packet user port
// Assumes: Fabric model answers maintenance accesses
// Notes:   Both stream sinks stall at random
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected %0t: got %h want %h", $time, (a), (e)); end end
module tb_top;
  import pum_pkg::*;
  localparam logic [31:0] FAULT_ADDR = 32'h0000FFFC;
  localparam logic [7:0]  SIZES [14] = '{8'h00, 8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F, 8'h5F,
                                         8'h7F, 8'h9F, 8'hBF, 8'hDF, 8'hFF, 8'h08, 8'h64};
  logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_ureq_tvalid = 1'b0, i_lreq_tready = 1'b0;
  logic i_lrsp_tvalid = 1'b0, i_ursp_tready = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0;
  logic i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  pum_fmt_t    i_fmt = PUM_FMT_HDR_ENC;
  pum_beat_t   i_ureq = '0, i_lrsp = '0, o_lreq, o_ursp, exp_rsp;
  logic [3:0]  i_lrsp_status = 4'h0, i_wstrb = 4'hF;
  logic [31:0] i_awaddr = '0, i_wdata = '0, i_araddr = '0, o_lreq_ids, o_ursp_ids, o_rdata;
  logic [31:0] rq_ids, rs_ids;
  logic o_ureq_tready, o_lreq_tvalid, o_size_bad, o_lrsp_tready, o_ursp_tvalid, o_awready;
  logic o_wready, o_bvalid, o_arready, o_rvalid, o_mreq_valid, i_mreq_ready;
  logic i_mcpl_valid, i_mcpl_write, size_exp;
  logic rq_first = 1'b1, rs_first = 1'b1, size_pend = 1'b0;
  logic [1:0]  o_bresp, o_rresp;
  pum_mreq_t   o_mreq;
  pum_mrsp_t   i_mcpl;
  int num_errors = 0, tests_run = 0;

  always #2.5 i_sys_clk = ~i_sys_clk;

  pum_user_port dut_u (.*);
  pum_fabric_model #(.FAULT_OFS(FAULT_ADDR[23:0])) fab_u (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .i_req_valid(o_mreq_valid), .o_req_ready(i_mreq_ready), .i_req(o_mreq),
    .o_cpl_valid(i_mcpl_valid), .o_cpl_write(i_mcpl_write), .o_cpl(i_mcpl));

  function automatic logic size_ok(input logic [7:0] s, input logic [3:0] c);
    return s < 8'h07 || s inside {8'h07, 8'h0F, 8'h1F, 8'h3F, 8'h7F, 8'hFF} ||
           (c == 4'h2 && s inside {8'h5F, 8'h9F, 8'hBF, 8'hDF});
  endfunction : size_ok

  // Stream sinks stall at random
  always @(posedge i_sys_clk) begin
    #1;
    i_lreq_tready = $urandom_range(3) != 0;
    i_ursp_tready = $urandom_range(3) != 0;
  end

  // Reference model checked at every beat that moves
  always @(posedge i_sys_clk) begin
    if (size_pend) `CHK(o_size_bad, size_exp)
    size_pend = 1'b0;
    `CHK(o_lreq_tvalid, i_ureq_tvalid)
    `CHK(o_ureq_tready, i_lreq_tready)
    `CHK(o_ursp_tvalid, i_lrsp_tvalid)
    `CHK(o_lrsp_tready, i_ursp_tready)
    if (i_ureq_tvalid && i_lreq_tready) begin
      if (rq_first) rq_ids = i_ureq.user;
      `CHK(o_ureq_tready, 1'b1)
      `CHK(o_lreq, i_ureq)
      `CHK(o_lreq_ids, rq_ids)
      size_pend = rq_first && i_fmt == PUM_FMT_HDR_ENC;
      size_exp = !size_ok(i_ureq.data[43:36], i_ureq.data[55:52]);
      rq_first = i_ureq.last;
    end
    if (i_lrsp_tvalid && i_ursp_tready) begin
      exp_rsp = i_lrsp;
      if (rs_first && i_fmt == PUM_FMT_HDR_ENC) exp_rsp.data[35] = i_lrsp_status != 4'h0;
      if (rs_first) rs_ids = i_lrsp.user;
      `CHK(o_ursp, exp_rsp)
      `CHK(o_ursp_ids, rs_ids)
      rs_first = i_lrsp.last;
    end
  end

  // One beat, with a random idle cycle before it
  task automatic put_beat(ref logic v, ref pum_beat_t b, ref logic rdy,
                          input logic [63:0] d, input logic lst);
    if ($urandom_range(3) == 0) begin
      v = 1'b0;
      @(posedge i_sys_clk) #1;
    end
    v = 1'b1;
    b = '{d, 8'hFF, $urandom, lst};
    do @(posedge i_sys_clk); while (!rdy);
    #1;
  endtask : put_beat

  task automatic send_pkt(input logic rsp);
    logic [63:0] h;
    int          nd;
    h = {$urandom, $urandom};
    h[55:52] = ($urandom_range(1) != 0) ? 4'h2 : 4'h5;
    h[43:36] = SIZES[$urandom_range(13)];
    h[2:0] = 3'h0;
    nd = (h[55:52] == 4'h2) ? 0 : $urandom_range((h[43:36] + 1) / 8, 1);
    if (rsp) i_lrsp_status = 4'($urandom_range(3));
    for (int i = 0; i <= nd; i++) begin
      if (rsp) put_beat(i_lrsp_tvalid, i_lrsp, i_ursp_tready, i ? {$urandom, $urandom} : h,
                        i == nd);
      else put_beat(i_ureq_tvalid, i_ureq, i_lreq_tready, i ? {$urandom, $urandom} : h, i == nd);
    end
  endtask : send_pkt

  // Raise a response ready after a random stall, return at the handshake edge
  task automatic take(input logic rd);
    repeat ($urandom_range(3)) #5;
    if (rd) i_rready = 1'b1;
    else i_bready = 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge i_sys_clk);
      if (rd ? o_rvalid : o_bvalid) break;
    end
  endtask : take

  task automatic mwrite(input int ord, input logic [31:0] a, input logic [3:0] s);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    i_awaddr = a;
    i_wdata = $urandom;
    i_wstrb = s;
    i_awvalid = ord != 1;
    i_wvalid = ord != 0;
    for (int n = 0; n < 30 && !(ad && dd); n++) begin
      @(posedge i_sys_clk);
      ad |= i_awvalid && o_awready;
      dd |= i_wvalid && o_wready;
      #1;
      i_awvalid = !ad;
      i_wvalid = !dd;
    end
    take(1'b0);
    `CHK(o_bvalid, 1'b1)
    `CHK(o_bresp, (a[23:0] == FAULT_ADDR[23:0] || s != 4'hF) ? 2'h2 : 2'h0)
    #1;
    i_bready = 1'b0;
  endtask : mwrite

  task automatic mread(input logic [31:0] a);
    i_araddr = a;
    i_arvalid = 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge i_sys_clk);
      if (o_arready) break;
    end
    #1;
    i_arvalid = 1'b0;
    take(1'b1);
    `CHK(o_rvalid, 1'b1)
    `CHK(o_rdata, ~a)
    `CHK(o_rresp, (a[23:0] == FAULT_ADDR[23:0]) ? 2'h2 : 2'h0)
    #1;
    i_rready = 1'b0;
  endtask : mread

  task automatic results;
    if (num_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  initial begin
    #100000;
    num_errors++;
    results();
  end

  // Both formats, streams and maintenance traffic at once
  initial begin
    void'($urandom(32'hD7931CBB));
    repeat (12) @(posedge i_sys_clk);
    #1;
    i_rst_n = 1'b1;
    for (int f = 0; f < 2; f++) begin
      i_fmt = pum_fmt_t'(f);
      fork
        begin repeat (30) send_pkt(1'b0); i_ureq_tvalid = 1'b0; end
        begin repeat (30) send_pkt(1'b1); i_lrsp_tvalid = 1'b0; end
        for (int k = 0; k < 6; k++) fork // local hop count zero
          mwrite(k % 3, k[0] ? FAULT_ADDR : 32'h60, (k == 4) ? 4'h3 : 4'hF);
          mread(k[1] ? FAULT_ADDR : 32'h64 + k);
        join
      join
      @(posedge i_sys_clk) #1;
    end
    results();
  end
endmodule : tb_top

bind pum_user_port pum_user_port_asserts chk_u (.*);
